// file: hw/ims_isa_if.sv
// ISA handshake: alternate-master ownership and slave I/O readiness
`default_nettype none
module ims_isa_if
   import ims_pkg::*;
(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   // ISA pins
   input  wire ims_pkg::ims_bus_in_type bus_i,
   output ims_pkg::ims_bus_out_type    bus_o,
   // Configuration
   input  wire logic [1:0]             dma_chan,    // 0..3 for channels 3,5,6,7
   input  wire logic [9:4]             io_base,     // Slave window base
   // Master requests from the core
   input  wire logic                   mst_valid,
   input  wire logic                   mst_write,
   input  wire logic                   mst_last,
   input  wire logic [23:0]            mst_addr,
   input  wire logic [15:0]            mst_wdata,
   output logic                        mst_done,    // Pulse per finished cycle
   output logic [15:0]                 mst_rdata,
   output logic                        mst_owner,   // Bus is ours
   // Slave accesses to the core
   output logic                        slv_rd,      // Pulse
   output logic                        slv_wr,      // Pulse
   output logic [3:0]                  slv_addr,
   output logic [15:0]                 slv_wdata,
   input  wire logic                   slv_ack,
   input  wire logic [15:0]            slv_rdata,
   // Held upper address
   output logic [23:20]                la_hold
);
   import ims_pkg::*;
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ims_mstate_type  ms_q, ms_d;            // Master sequencer
   ims_sstate_type  ss_q, ss_d;            // Slave sequencer
   ims_bus_out_type out_q, out_d;          // Every pin driven from here
   logic [1:0]      ch_q, ch_d;            // Channel held for this ownership
   logic [23:0]     addr_q, addr_d;        // Byte address of current cycle, as driven on SA and LA
   logic [15:0]     wdat_q, wdat_d;        // Write data of current cycle
   logic            wr_q, wr_d;            // Current cycle is a write
   logic            last_q, last_d;        // Current cycle ends the burst
   logic [3:0]      cnt_q, cnt_d;          // Least strobe width counter
   logic            done_q, done_d;
   logic [15:0]     rdat_q, rdat_d;
   logic            srd_q, srd_d;
   logic            swr_q, swr_d;
   logic [3:0]      sadr_q, sadr_d;
   logic [15:0]     swd_q, swd_d;
   logic [23:20]    la_q, la_d;
   logic            bo_start;              // Ownership just given up
   logic            bo_ready;              // Gap has run out
   logic            contend;               // Foreign master on the bus
   logic            dack_ok;               // Usable acknowledge
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Slave hit: host must have AEN low for our cycles
   function automatic logic io_hit(input ims_bus_in_type b, input logic [9:4] base);
      io_hit = !b.aen && (b.sa[IO_MSB:IO_LSB] == base);
   endfunction
   // Driver release pattern, shared by reset and hand-back
   function automatic ims_bus_out_type released();
      ims_bus_out_type r;
      r              = '0;
      r.drq_oe_n     = 1'b0;       // Request pins stay driven, low
      r.iochrdy_oe_n = 1'b1;
      r.master_oe_n  = 1'b1;
      r.memr_n       = 1'b1;
      r.memw_n       = 1'b1;
      r.sbhe_n       = 1'b1;
      r.ctl_oe_n     = 1'b1;
      r.addr_oe_n    = 1'b1;
      r.sd_oe_n      = 1'b1;
      released       = r;
   endfunction
   // Only our own channel's acknowledge counts, and never during refresh
   assign dack_ok = !bus_i.dack_n[ch_q] && bus_i.ref_n;
   // A master line pulled low while we do not pull it is another master
   assign contend = !bus_i.master_n && out_q.master_oe_n;
   // ----------------------------------------------------------------
   // Gap timer between requests
   // ----------------------------------------------------------------
   ims_backoff u_backoff (
      .core_clk (core_clk),
      .nrst     (nrst),
      .start    (bo_start),
      .contend  (contend),
      .ready    (bo_ready)
   );
   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Master and slave sequencers share the pin register; they never overlap
   // because the host cannot address us while we own the bus.
   always_comb begin
      ms_d     = ms_q;
      ss_d     = ss_q;
      out_d    = out_q;
      ch_d     = ch_q;
      addr_d   = addr_q;
      wdat_d   = wdat_q;
      wr_d     = wr_q;
      last_d   = last_q;
      cnt_d    = cnt_q;
      done_d   = 1'b0;
      rdat_d   = rdat_q;
      srd_d    = 1'b0;
      swr_d    = 1'b0;
      sadr_d   = sadr_q;
      swd_d    = swd_q;
      la_d     = la_q;
      bo_start = 1'b0;
      // Upper address follows LA while BALE is high, holds after it falls
      if (bus_i.bale) la_d = bus_i.la[23:20];
      // Master sequencer
      case (ms_q)
         MS_IDLE: begin
            // New request only after the gap has run out
            if (mst_valid && bo_ready) begin
               ch_d   = dma_chan;
               addr_d = mst_addr;
               wdat_d = mst_wdata;
               wr_d   = mst_write;
               last_d = mst_last;
               out_d.drq = 4'h1 << dma_chan;
               ms_d   = MS_REQ;
            end
         end
         MS_REQ: begin
            // Request stays up until acknowledged
            if (dack_ok) begin
               out_d.master_oe_n = 1'b0;
               ms_d = MS_OWN;
            end
         end
         MS_OWN: begin
            // Two cycles of MASTER alone (this state and MS_ADDR) before our drivers turn on
            ms_d = MS_ADDR;
         end
         MS_ADDR: begin
            // Address, byte enable, write data and strobe all go out together
            out_d.addr_oe_n = 1'b0;
            out_d.sa        = addr_q[19:0];
            out_d.la        = addr_q[23:17];
            out_d.ctl_oe_n  = 1'b0;
            out_d.sbhe_n    = 1'b0;
            out_d.sd        = wdat_q;
            out_d.sd_oe_n   = !wr_q;
            cnt_d           = CMD_CNT_INIT;
            out_d.memw_n    = !wr_q;
            out_d.memr_n    = wr_q;
            ms_d            = MS_STRB;
         end
         MS_STRB: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (bus_i.iochrdy) begin
               // Read data taken as the strobe ends
               if (!wr_q) rdat_d = bus_i.sd;
               done_d       = 1'b1;
               out_d.memr_n = 1'b1;
               out_d.memw_n = 1'b1;
               ms_d         = MS_NEXT;
            end
         end
         MS_NEXT: begin
            if (mst_valid && !last_q) begin
               // Burst continues without giving up the bus
               addr_d = mst_addr;
               wdat_d = mst_wdata;
               wr_d   = mst_write;
               last_d = mst_last;
               ms_d   = MS_ADDR;
            end else begin
               // Hand-back: all but the request drivers float, request and MASTER fall together
               out_d    = released();
               bo_start = 1'b1;
               ms_d     = MS_IDLE;
            end
         end
         default: begin
            out_d = released();
            ms_d  = MS_IDLE;
         end
      endcase
      // Slave sequencer, only while another party owns the bus
      case (ss_q)
         SS_IDLE: begin
            if (out_q.master_oe_n && io_hit(bus_i, io_base)) begin
               sadr_d = bus_i.sa[3:0];
               if (!bus_i.ior_n) begin
                  // Hold the host off until read data is on the bus
                  out_d.iochrdy_oe_n = 1'b0;
                  srd_d = 1'b1;
                  ss_d  = SS_WAIT;
               end else if (!bus_i.iow_n) begin
                  // Data captured at this edge, so ready need not fall
                  swd_d = bus_i.sd;
                  swr_d = 1'b1;
                  ss_d  = SS_HOLD;
               end
            end
         end
         SS_WAIT: begin
            if (slv_ack) begin
               out_d.sd           = slv_rdata;
               out_d.sd_oe_n      = 1'b0;
               out_d.iochrdy_oe_n = 1'b1;
               ss_d               = SS_HOLD;
            end
         end
         SS_HOLD: begin
            // Data stays on the bus until the host lifts its strobe
            if (bus_i.ior_n && bus_i.iow_n) begin
               out_d.sd_oe_n = 1'b1;
               ss_d          = SS_IDLE;
            end
         end
         default: begin
            ss_d = SS_IDLE;
         end
      endcase
   end
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ms_q   <= MS_IDLE;
         ss_q   <= SS_IDLE;
         out_q  <= released();
         ch_q   <= 2'h0;
         addr_q <= 24'h000000;
         wdat_q <= 16'h0000;
         wr_q   <= 1'b0;
         last_q <= 1'b0;
         cnt_q  <= 4'h0;
         done_q <= 1'b0;
         rdat_q <= 16'h0000;
         srd_q  <= 1'b0;
         swr_q  <= 1'b0;
         sadr_q <= 4'h0;
         swd_q  <= 16'h0000;
         la_q   <= 4'h0;
      end else begin
         ms_q   <= ms_d;
         ss_q   <= ss_d;
         out_q  <= out_d;
         ch_q   <= ch_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         wr_q   <= wr_d;
         last_q <= last_d;
         cnt_q  <= cnt_d;
         done_q <= done_d;
         rdat_q <= rdat_d;
         srd_q  <= srd_d;
         swr_q  <= swr_d;
         sadr_q <= sadr_d;
         swd_q  <= swd_d;
         la_q   <= la_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------------------------------
   assign bus_o     = out_q;
   assign mst_done  = done_q;
   assign mst_rdata = rdat_q;
   assign mst_owner = !out_q.master_oe_n;
   assign slv_rd    = srd_q;
   assign slv_wr    = swr_q;
   assign slv_addr  = sadr_q;
   assign slv_wdata = swd_q;
   assign la_hold   = la_q;
endmodule
`default_nettype wire

// file: hw/ims_pkg.sv
// Package: constants, bus carriers and state codes for the ISA handshake block
`default_nettype none
package ims_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;                 // core_clk period
   localparam int CMD_MIN_NS    = 250;                // Least strobe width of own cycles
   localparam int CMD_CYC       = (CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CMD_CNT_INIT = 4'(CMD_CYC - 1);
   localparam logic [7:0] BACKOFF_MIN  = 8'h08;       // Shortest gap between requests
   localparam logic [7:0] BACKOFF_MAX  = 8'h80;       // Longest gap between requests
   localparam logic [7:0] BACKOFF_RST  = BACKOFF_MIN; // Gap length after reset
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NCH     = 4;   // Channels 3,5,6,7 sit at index 0..3
   localparam int IO_LSB  = 4;   // Slave window is 16 bytes
   localparam int IO_MSB  = 9;   // Slave decode uses address bits 9..4
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic          aen;        // High during DMA cycles
      logic          bale;       // Address latch strobe
      logic [3:0]    dack_n;     // Acknowledge per channel
      logic          ref_n;      // Refresh in progress
      logic          ior_n;      // I/O read strobe
      logic          iow_n;      // I/O write strobe
      logic          iochrdy;    // Ready line as seen on the wire
      logic          master_n;   // Master line as seen on the wire
      logic [23:17]  la;         // Unlatched address
      logic [19:0]   sa;         // Latched address
      logic [15:0]   sd;         // Data bus
   } ims_bus_in_type;
   typedef struct packed {
      logic [3:0]    drq;        // Request per channel
      logic          drq_oe_n;   // Request drivers enabled
      logic          iochrdy;    // Open drain level, always low
      logic          iochrdy_oe_n; // Pull ready low
      logic          master_n;   // Open drain level, always low
      logic          master_oe_n;  // Pull master low
      logic          memr_n;     // Own memory read strobe
      logic          memw_n;     // Own memory write strobe
      logic          sbhe_n;     // High byte enable
      logic          ctl_oe_n;   // Strobe and byte enable drivers
      logic [23:17]  la;         // Own unlatched address
      logic [19:0]   sa;         // Own latched address
      logic          addr_oe_n;  // Address drivers
      logic [15:0]   sd;         // Data out
      logic          sd_oe_n;    // Data drivers
   } ims_bus_out_type;
   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      MS_IDLE = 6'h01, MS_REQ  = 6'h02, MS_OWN = 6'h04,
      MS_ADDR = 6'h08, MS_STRB = 6'h10, MS_NEXT = 6'h20
   } ims_mstate_type;
   typedef enum logic [2:0] {
      SS_IDLE = 3'h1, SS_WAIT = 3'h2, SS_HOLD = 3'h4
   } ims_sstate_type;
endpackage
`default_nettype wire

// file: hw/ims_backoff.sv
// Adaptive gap timer placed between back-to-back bus requests
`default_nettype none
module ims_backoff
   import ims_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // Control
   input  wire logic start,      // Pulse when ownership is given up
   input  wire logic contend,    // Another master was seen on the bus
   output logic      ready       // Gap has run out
);
   // ----------------------------------------------------------------
   // Gap length and counter
   // ----------------------------------------------------------------
   logic [7:0] gap_q, gap_d;     // Current gap length
   logic [7:0] cnt_q, cnt_d;     // Remaining cycles of gap
   logic       seen_q, seen_d;   // Contention seen in this gap

   // Next values: grow the gap when another master competes, shrink it when alone
   always_comb begin
      gap_d  = gap_q;
      cnt_d  = cnt_q;
      seen_d = seen_q | contend;
      if (start) begin
         cnt_d  = gap_q;
         seen_d = 1'b0;
      end else if (cnt_q != 8'h00) begin
         cnt_d = cnt_q - 8'h01;
         if (cnt_q == 8'h01) begin
            // Doubling lets the other master finish its burst first
            if (seen_d && gap_q < BACKOFF_MAX) gap_d = {gap_q[6:0], 1'b0};
            else if (!seen_d && gap_q > BACKOFF_MIN) gap_d = {1'b0, gap_q[7:1]};
         end
      end
   end

   // Registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         gap_q  <= BACKOFF_RST;
         cnt_q  <= 8'h00;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= gap_d;
         cnt_q  <= cnt_d;
         seen_q <= seen_d;
      end
   end

   assign ready = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// file: testbench/ims_isa_monitor.sv
// Checker module for the ISA handshake block ports, with its bind
`default_nettype none
module ims_isa_monitor
   import ims_pkg::*;
(
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    nrst,
   // Bus pins
   input wire ims_pkg::ims_bus_in_type  bus_i,
   input wire ims_pkg::ims_bus_out_type bus_o,
   // Configuration and core side
   input wire logic [1:0]              dma_chan,
   input wire logic [9:4]              io_base,
   input wire logic                    slv_rd,
   input wire logic [23:20]            la_hold
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Clocking
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Ownership handshake
   a_ack_gives_master: assert property (
      bus_o.master_oe_n && bus_i.ref_n && |(bus_o.drq & ~bus_i.dack_n) |=> !bus_o.master_oe_n)
      else $error("MASTER not taken after acknowledge");
   a_refresh_masks_ack: assert property (
      bus_o.master_oe_n && !bus_i.ref_n |=> bus_o.master_oe_n)
      else $error("MASTER taken during refresh");
   a_drq_held_wait: assert property (
      |bus_o.drq && bus_o.master_oe_n |=> |bus_o.drq)
      else $error("Request dropped before ownership");
   a_chan_own_line: assert property (
      $rose(|bus_o.drq) |-> bus_o.drq == 4'(4'h1 << dma_chan))
      else $error("Request on wrong channel line");
   a_gap_between_req: assert property (
      $fell(|bus_o.drq) |-> (bus_o.drq == 4'h0) [*8])
      else $error("Request gap too short");
   // Own cycles: width, stretch and driver enables
   a_strobe_min_width: assert property (
      $fell(bus_o.memr_n & bus_o.memw_n) |-> !(bus_o.memr_n & bus_o.memw_n) [*5])
      else $error("Strobe shorter than minimum");
   a_wait_stretch: assert property (
      !(bus_o.memr_n & bus_o.memw_n) && !bus_i.iochrdy |=> !(bus_o.memr_n & bus_o.memw_n))
      else $error("Strobe ended while ready low");
   a_drive_as_master: assert property (
      !bus_o.addr_oe_n |-> !bus_o.ctl_oe_n && !bus_o.sbhe_n && !bus_o.master_oe_n)
      else $error("Address driven without ownership");
   a_release_float: assert property (
      $rose(bus_o.master_oe_n) |->
         bus_o.addr_oe_n && bus_o.ctl_oe_n && bus_o.sd_oe_n && bus_o.drq == 4'h0)
      else $error("Drivers or request left on at release");
   // Slave side
   a_slave_decode: assert property (
      slv_rd |-> !$past(bus_i.aen) && !$past(bus_i.ior_n) && $past(bus_i.sa[9:4]) == $past(io_base))
      else $error("Slave read without valid decode");
   a_ready_with_data: assert property (
      $rose(bus_o.iochrdy_oe_n) |-> !bus_o.sd_oe_n)
      else $error("Ready released before data driven");
   a_upper_addr_held: assert property (
      !$past(bus_i.bale) |-> $stable(la_hold))
      else $error("Held upper address moved without latch strobe");
endmodule

bind ims_isa_if ims_isa_monitor u_mon (
   .core_clk(core_clk), .nrst(nrst), .bus_i(bus_i), .bus_o(bus_o),
   .dma_chan(dma_chan), .io_base(io_base), .slv_rd(slv_rd), .la_hold(la_hold)
);
`default_nettype wire

// file: testbench/ims_host_model.sv
// Permanent master model: DMA acknowledge, memory data and wait states
`default_nettype none
module ims_host_model
   import ims_pkg::*;
#(
   parameter logic [15:0] MEM_WORD = 16'h5AC3  // Word returned on memory reads
)
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // Device side
   input  wire logic [3:0] drq,
   input  wire logic       strobe_n,   // Own read and write strobes anded
   input  wire logic       memr_n,
   // Commands from the bench
   input  wire logic [3:0] wait_cyc,   // Wait states per cycle
   input  wire logic       wrong_ch,   // Acknowledge on a rotated channel
   // Answers
   output logic [3:0]      dack_n,
   output logic            aen,
   output logic            rdy_low,    // Pulls ready low
   output logic            drv_sd,
   output logic [15:0]     sd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;   // Wait states left
   logic       stb_q;   // Strobe level seen last time

   // Answers move just after the falling edge, like the bench
   always @(negedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dack_n <= 4'hF;
         cnt_q  <= 4'h0;
         stb_q  <= 1'b1;
      end else begin
         dack_n <= wrong_ch ? ~{drq[2:0], drq[3]} : ~drq;
         stb_q  <= strobe_n;
         if (stb_q && !strobe_n) begin
            cnt_q <= wait_cyc;               // New cycle starts its wait
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
   // Ready low from the strobe edge, before the counter is loaded
   assign rdy_low = (cnt_q != 4'h0) || (stb_q && !strobe_n && wait_cyc != 4'h0);
   assign aen     = (dack_n != 4'hF);
   assign drv_sd  = !memr_n;
   assign sd      = drv_sd ? MEM_WORD : 16'h0000;
endmodule
`default_nettype wire

// file: testbench/ims_isa_if_tb.sv
// Self-checking bench for the ISA handshake block
`default_nettype none
module ims_isa_if_tb;
   import ims_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] RD_WORD = 16'h5AC3;  // Memory word of the model
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic            core_clk, nrst;
   logic            t_aen, bale, ref_n, ior_n, iow_n, sd_hold, wrong_ch, slv_ack;
   logic [23:17]    t_la;
   logic [19:0]     t_sa;
   logic [15:0]     t_sd, slv_rdata, mst_wdata, mst_rdata, slv_wdata, h_sd;
   logic [1:0]      dma_chan;
   logic [9:4]      io_base;
   logic [3:0]      wait_cyc, h_dack_n, slv_addr;
   logic [23:0]     mst_addr;
   logic            mst_valid, mst_write, mst_last, mst_done, mst_owner;
   logic            slv_rd, slv_wr, h_aen, h_rdy_low, h_drv;
   logic [23:20]    la_hold;
   ims_bus_in_type  bus_i;
   ims_bus_out_type bus_o;
   int              err_count, n_compared, cyc;

   // Wire levels: pull-ups on ready and master, data from whoever drives
   assign bus_i = {t_aen | h_aen, bale, h_dack_n, ref_n, ior_n, iow_n,
      ~(~bus_o.iochrdy_oe_n | h_rdy_low), bus_o.master_oe_n,
      bus_o.addr_oe_n ? t_la : bus_o.la, bus_o.addr_oe_n ? t_sa : bus_o.sa,
      !bus_o.sd_oe_n ? bus_o.sd : h_drv ? h_sd : t_sd};

   ims_isa_if u_dut (.core_clk(core_clk), .nrst(nrst), .bus_i(bus_i), .bus_o(bus_o),
      .dma_chan(dma_chan), .io_base(io_base), .mst_valid(mst_valid), .mst_write(mst_write),
      .mst_last(mst_last), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_done(mst_done),
      .mst_rdata(mst_rdata), .mst_owner(mst_owner), .slv_rd(slv_rd), .slv_wr(slv_wr),
      .slv_addr(slv_addr), .slv_wdata(slv_wdata), .slv_ack(slv_ack),
      .slv_rdata(slv_rdata), .la_hold(la_hold));
   ims_host_model #(.MEM_WORD(RD_WORD)) u_host (.core_clk(core_clk), .nrst(nrst),
      .drq(bus_o.drq), .strobe_n(bus_o.memr_n & bus_o.memw_n), .memr_n(bus_o.memr_n),
      .wait_cyc(wait_cyc), .wrong_ch(wrong_ch), .dack_n(h_dack_n), .aen(h_aen),
      .rdy_low(h_rdy_low), .drv_sd(h_drv), .sd(h_sd));

   // ----------------------------------------------------------------
   // Clock, released data bus, timeout
   // ----------------------------------------------------------------
   always #25 core_clk = ~core_clk;
   // Undriven data changes every cycle so stale values cannot pass
   always @(negedge core_clk) if (!sd_hold) t_sd <= ~t_sd;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // All drivers but the request's off, request driven low after reset
   task automatic t_reset;
      @(negedge core_clk);
      check({bus_o.drq, bus_o.drq_oe_n, bus_o.iochrdy, bus_o.master_n, bus_o.master_oe_n,
             bus_o.addr_oe_n, bus_o.ctl_oe_n, bus_o.sd_oe_n, bus_o.iochrdy_oe_n,
             bus_o.memr_n, bus_o.memw_n, bus_o.sbhe_n}, {7'h00, 8'hFF});
   endtask

   // Upper address captured by the latch strobe, then held
   task automatic t_latch;
      @(negedge core_clk);
      bale = 1'b1;
      t_la = 7'h5A;
      @(negedge core_clk);
      bale = 1'b0;
      @(negedge core_clk);
      t_la = 7'h25;
      repeat (2) @(negedge core_clk);
      check(la_hold, 4'hB);
   endtask

   // One master cycle; blk 1 = refresh during ack, 2 = ack on wrong channel
   task automatic t_master(input logic [1:0] ch, input logic wr, input logic [3:0] ws,
                           input logic [1:0] blk);
      int n;
      int low;
      @(negedge core_clk);
      dma_chan  = ch;
      wait_cyc  = ws;
      mst_write = wr;
      mst_addr  = {4'hA, ch, 18'h0ABC4};
      mst_wdata = {14'h3C01, ch};
      mst_valid = 1'b1;
      if (blk != 2'd0) begin
         ref_n    = (blk != 2'd1);
         wrong_ch = (blk == 2'd2);
         repeat (16) @(negedge core_clk);
         check(bus_o.master_oe_n, 1'b1);
         check(bus_o.drq, 4'(4'h1 << ch));
         ref_n    = 1'b1;
         wrong_ch = 1'b0;
      end
      low = 0;
      for (n = 0; n < 400 && mst_done !== 1'b1; n++) begin
         @(negedge core_clk);
         if ((wr ? bus_o.memw_n : bus_o.memr_n) === 1'b0) low++;
         if (low == 1 && mst_done !== 1'b1) begin
            check(bus_o.sa, mst_addr[19:0]);
            check(bus_o.la, mst_addr[23:17]);
            check(bus_o.sbhe_n, 1'b0);
            check(bus_o.drq, 4'(4'h1 << ch));
            check(mst_owner, 1'b1);
            if (wr) check(bus_o.sd, mst_wdata);
         end
      end
      mst_valid = 1'b0;
      check(mst_done, 1'b1);
      check(low, (ws < CMD_CYC) ? CMD_CYC : ws + 1);
      if (!wr) check(mst_rdata, RD_WORD);
      for (n = 0; n < 8 && bus_o.master_oe_n !== 1'b1; n++) @(negedge core_clk);
      check({bus_o.drq, bus_o.addr_oe_n, bus_o.ctl_oe_n, bus_o.sd_oe_n},
            {4'h0, 3'h7});
   endtask

   // Slave access; en raises address enable, miss breaks the decode
   task automatic t_slave(input logic rd, input logic en, input logic miss,
                          input logic [15:0] val);
      int n;
      logic hit;
      sd_hold = 1'b1;
      @(negedge core_clk);
      t_aen   = en;
      t_sa    = {10'h000, io_base ^ {5'h00, miss}, 4'h6};
      t_sd    = val;
      ior_n   = !rd;
      iow_n   = rd;
      hit     = 1'b0;
      for (n = 0; n < 3 && !hit; n++) begin
         @(negedge core_clk);
         hit = ((rd ? slv_rd : slv_wr) === 1'b1);
      end
      check(hit, !en && !miss);
      if (hit) begin
         check(slv_addr, 4'h6);
         check(bus_o.iochrdy_oe_n, !rd);
         if (!rd) check(slv_wdata, val);
         if (rd) begin
            slv_rdata = val;
            slv_ack   = 1'b1;
            @(negedge core_clk);
            slv_ack = 1'b0;
            for (n = 0; n < 6 && bus_o.iochrdy_oe_n !== 1'b1; n++) @(negedge core_clk);
            check({bus_o.sd_oe_n, bus_o.sd}, {1'b0, val});
         end
      end
      ior_n   = 1'b1;
      iow_n   = 1'b1;
      t_aen   = 1'b0;
      sd_hold = 1'b0;
      repeat (2) @(negedge core_clk);
      check(bus_o.sd_oe_n, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {core_clk, nrst, t_aen, bale, ior_n, iow_n, sd_hold, wrong_ch, slv_ack} = 9'h018;
      {ref_n, mst_valid, mst_write, mst_last} = 4'h9;
      {t_la, t_sa, t_sd, slv_rdata, mst_wdata, mst_addr} = '0;
      {dma_chan, wait_cyc, io_base} = {2'h0, 4'h0, 6'h2C};
      {err_count, n_compared, cyc} = '0;
      repeat (20) @(negedge core_clk);
      nrst = 1'b1;
      t_reset();
      t_latch();
      for (int i = 0; i < 4; i++) t_master(2'(i), 1'(i), 4'h0, 2'd0);
      t_master(2'd1, 1'b0, 4'h9, 2'd0);
      t_master(2'd2, 1'b1, 4'h0, 2'd1);
      t_master(2'd3, 1'b0, 4'h0, 2'd2);
      t_slave(1'b1, 1'b0, 1'b0, 16'hC0DE);
      t_slave(1'b0, 1'b0, 1'b0, 16'h0F0F);
      t_slave(1'b1, 1'b1, 1'b0, 16'h1111);
      t_slave(1'b0, 1'b0, 1'b1, 16'h2222);
      nrst = 1'b0;
      repeat (3) @(negedge core_clk);
      nrst = 1'b1;
      t_reset();
      t_master(2'd0, 1'b0, 4'h2, 2'd0);
      wrap_up();
   end
endmodule
`default_nettype wire
